// [status_lamp_defines.svh]
// Constants for the status output and lamp block: offsets, fields, resets, times.
// Assumes inclusion by bare name from the main design file and the bench.
`ifndef STATUS_LAMP_DEFINES_SVH
`define STATUS_LAMP_DEFINES_SVH

// Register byte offsets
`define OFS_CTRL      12'h000
`define OFS_SRC       12'h004
`define OFS_LAMP      12'h008
`define OFS_STATUS    12'h00c
`define OFS_IRQ_STAT  12'h010
`define OFS_IRQ_EN    12'h014
`define OFS_IRQ_CLR   12'h018
`define OFS_CARD      12'h01c

// Control register fields
`define CTRL_CFG_BIT   0
`define CTRL_WAKE_BIT  1
`define CTRL_IOL_END   2

// Lamp register fields
`define LAMP_COMB_BIT  0
`define LAMP_SAFETY_SWITCHING_OUTPUTS_EN   1

// Card register fields
`define CARD_LOAD_BIT  0
`define CARD_SAVE_BIT  1

// Interrupt bit positions
`define IRQ_SIG_DONE   0
`define IRQ_CARD_DONE  1
`define IRQ_WAKE       2
`define IRQ_WIDTH      3

// Reset values
`define SRC_RESET      3'h0
`define LAMP_RESET     2'h3

// Timing: display interval in seconds, clock in Hz
`define SIG_SHOW_S     30
`define CLK_HZ         25000000
`define FLASH_CYCLES   24'h5f5e10

`endif

// [status_lamp_pkg.sv]
// Types shared by the status output and lamp block.
// Assumes the defines header is available by bare name.
package status_lamp_pkg;

  // Switching output source selection
  typedef enum logic [2:0] {
    SRC_ACK   = 3'b000,
    SRC_SAFE  = 3'b001,
    SRC_MUTE  = 3'b010,
    SRC_DIRT  = 3'b011,
    SRC_SYNC  = 3'b100,
    SRC_READY = 3'b101,
    SRC_OFF   = 3'b110
  } out_src_t;

  // Lamp colours
  typedef enum logic [1:0] {
    LAMP_OFF   = 2'b00,
    LAMP_WHITE = 2'b01,
    LAMP_GREEN = 2'b10,
    LAMP_RED   = 2'b11
  } lamp_color_t;

  // Shared line usage
  typedef enum logic [0:0] {
    LINE_SWITCH = 1'b0,
    LINE_COMM   = 1'b1
  } line_mode_t;

endpackage

// [pin_sync.sv]
// Two-stage synchroniser for a bundle of pin levels.
// Assumes a single clock; enable freezes the stages.
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         clkEn,
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] pinOut
);

  logic [W-1:0] stage1Reg; // First stage, read only by second

  // Two flops before any logic sees the pins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stage1Reg <= '0;
      pinOut    <= '0;
    end else if (clkEn) begin
      stage1Reg <= pinIn;
      pinOut    <= stage1Reg;
    end
  end

endmodule
`default_nettype wire

// [status_output_and_lamp_logic.sv]
// Status switching output, end-cap lamp driver, signal display timer and card transfer control.
// Assumes an APB master on clk, status pins from the safety core, lamp driver outside.
//
// Notes on behaviour
// - Idle line acts as high-side switching output
// - Wake-up request moves line to communication
// - One selectable output source, including off
// - Acknowledgment prompt is default source
// - Contamination source: dirt or weak signal
// - Sync source active only while synchronised
// - Ready, safety and muting sources follow status
// - Lamp faults never affect protective function
// - Muting-only and combined lamp colour modes
// - Safety lamp display may be disabled
// - Signal strength shown 30 s after power-up
// - Configuration keeps signal display on indefinitely
// - Card load and save both supported
`timescale 1ns/10ps
`default_nettype none
`include "status_lamp_defines.svh"
module status_output_and_lamp_logic
  import status_lamp_pkg::*;
#(
  parameter int SHOW_CYCLES = `SIG_SHOW_S * `CLK_HZ
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        clkEn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Status pins from the safety core
  input  wire logic        ackPending,
  input  wire logic        safety_switching_outputs,
  input  wire logic        mutingActive,
  input  wire logic        overrideActive,
  input  wire logic        dirtWarning,
  input  wire logic        syncRun,
  input  wire logic        protective_sensor_unitReady,
  input  wire logic        wakeRequest,
  // Card controller handshake
  input  wire logic        cardBusy,
  output logic             cardLoad,
  output logic             cardSave,
  // Shared line: high-side output, enable low means driven
  output logic             lineOut,
  output logic             lineOe_n,
  output logic             lineCommMode,
  // Lamp and display
  output logic             lampWhite,
  output logic             lampGreen,
  output logic             lampRed,
  output logic             sigShow,
  output logic             irq
);

  // Synchronised status pins
  logic [8:0] pinRaw;
  logic [8:0] pinSync;
  assign pinRaw = {cardBusy, wakeRequest, protective_sensor_unitReady, syncRun, dirtWarning,
                   overrideActive, mutingActive, safety_switching_outputs, ackPending};

  pin_sync #(.W(9)) u_sync (
    .clk    (clk),
    .rst_n  (rst_n),
    .clkEn  (clkEn),
    .pinIn  (pinRaw),
    .pinOut (pinSync)
  );

  // Named views of the synchronised pins
  logic sAck, sSafe, sMute, sOvr, sDirt, sSync, sReady, sWake, sBusy;
  assign {sBusy, sWake, sReady, sSync, sDirt, sOvr, sMute, sSafe, sAck} = pinSync;

  // Registers
  logic                  cfgActive_reg;   // Configuration in progress
  out_src_t              src_reg;         // Switching output source
  logic                  lampComb_reg;    // Combined lamp mode
  logic                  lampSafeEn_reg;  // Safety part of lamp enabled
  line_mode_t            lineMode_reg;    // Shared line usage
  logic [`IRQ_WIDTH-1:0] irqStat_reg;     // Sticky events
  logic [`IRQ_WIDTH-1:0] irqEn_reg;       // Interrupt enables
  logic                  valid_reg;       // Sources evaluated since reset
  logic [31:0]           showCnt_reg;     // Display timer
  logic                  showDone_reg;    // Power-up interval over
  logic [23:0]           flashCnt_reg;    // Flash divider
  logic                  flash_reg;       // Flash phase
  logic                  busyDly_reg;     // Previous card busy
  logic                  wakeDly_reg;     // Previous wake level
  logic                  showDly_reg;     // Previous display state

  // Bus decode
  // Writes land at the access edge; reads are captured one edge earlier
  logic wrEn, rdEn, hit;
  assign wrEn    = psel && penable && pwrite && clkEn;
  assign rdEn    = psel && !penable && !pwrite;
  assign pready  = 1'b1;       // Zero wait states
  assign pslverr = psel && penable && !hit;

  // Address match helper
  function automatic logic isAddr(input logic [11:0] a, input logic [11:0] ofs);
    return a == ofs;
  endfunction

  always_comb begin
    if (isAddr(paddr, `OFS_CTRL)) hit = 1'b1;
    else if (isAddr(paddr, `OFS_SRC)) hit = 1'b1;
    else if (isAddr(paddr, `OFS_LAMP)) hit = 1'b1;
    else if (isAddr(paddr, `OFS_STATUS)) hit = 1'b1;
    else if (isAddr(paddr, `OFS_IRQ_STAT)) hit = 1'b1;
    else if (isAddr(paddr, `OFS_IRQ_EN)) hit = 1'b1;
    else if (isAddr(paddr, `OFS_IRQ_CLR)) hit = 1'b1;
    else if (isAddr(paddr, `OFS_CARD)) hit = 1'b1;
    else hit = 1'b0;
  end

  // Read data captured in setup so it is ready in the access phase
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata <= 32'h0;
    end else if (clkEn && rdEn) begin
      if (isAddr(paddr, `OFS_CTRL)) prdata <= {30'h0, lineMode_reg == LINE_COMM, cfgActive_reg};
      else if (isAddr(paddr, `OFS_SRC)) prdata <= {29'h0, src_reg};
      else if (isAddr(paddr, `OFS_LAMP)) prdata <= {30'h0, lampSafeEn_reg, lampComb_reg};
      else if (isAddr(paddr, `OFS_STATUS))
        prdata <= {21'h0, sigShow, sBusy, pinSync[6:0], lineOut, valid_reg};
      else if (isAddr(paddr, `OFS_IRQ_STAT)) prdata <= {29'h0, irqStat_reg};
      else if (isAddr(paddr, `OFS_IRQ_EN)) prdata <= {29'h0, irqEn_reg};
      else if (isAddr(paddr, `OFS_CARD)) prdata <= {30'h0, cardSave, cardLoad};
      else prdata <= 32'h0; // Clear register and unmapped read as zero
    end
  end

  // Configuration and lamp settings
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfgActive_reg  <= 1'b0;
      src_reg        <= out_src_t'(`SRC_RESET);
      lampComb_reg   <= 1'(`LAMP_RESET);
      lampSafeEn_reg <= 1'(`LAMP_RESET >> 1);
    end else if (wrEn) begin
      if (isAddr(paddr, `OFS_CTRL)) begin
        cfgActive_reg <= pwdata[`CTRL_CFG_BIT];
      end else if (isAddr(paddr, `OFS_SRC)) begin
        // Unused code falls back to off, keeping one source only
        if (pwdata[2:0] > 3'h6) src_reg <= SRC_OFF;
        else src_reg <= out_src_t'(pwdata[2:0]);
      end else if (isAddr(paddr, `OFS_LAMP)) begin
        lampComb_reg   <= pwdata[`LAMP_COMB_BIT];
        lampSafeEn_reg <= pwdata[`LAMP_SAFETY_SWITCHING_OUTPUTS_EN];
      end
    end
  end

  // Line mode: wake-up takes the line, software hands it back
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lineMode_reg <= LINE_SWITCH;
      wakeDly_reg  <= 1'b0;
    end else if (clkEn) begin
      wakeDly_reg <= sWake;
      if (sWake && !wakeDly_reg) begin
        lineMode_reg <= LINE_COMM;
      end else if (wrEn && isAddr(paddr, `OFS_CTRL) && pwdata[`CTRL_IOL_END]) begin
        lineMode_reg <= LINE_SWITCH;
      end
    end
  end
  assign lineCommMode = lineMode_reg == LINE_COMM;

  // Source evaluation flag, output stays low until first evaluation
  always_ff @(posedge clk) begin
    if (!rst_n) valid_reg <= 1'b0;
    else if (clkEn) valid_reg <= 1'b1;
  end

  // Switching output from the selected source
  logic srcLevel;
  always_comb begin
    case (src_reg)
      SRC_ACK:   srcLevel = sAck;
      SRC_SAFE:  srcLevel = sSafe;
      SRC_MUTE:  srcLevel = sMute;
      SRC_DIRT:  srcLevel = sDirt;
      SRC_SYNC:  srcLevel = sSync;
      SRC_READY: srcLevel = sReady;
      default:   srcLevel = 1'b0;
    endcase
  end

  // Driven high-side only while the line is not communicating
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lineOut  <= 1'b0;
      lineOe_n <= 1'b1;
    end else if (clkEn) begin
      lineOut  <= valid_reg && lineMode_reg == LINE_SWITCH && srcLevel;
      lineOe_n <= lineMode_reg != LINE_SWITCH;
    end
  end

  // Flash divider for override indication
  // Free-running, so a flash starts in an arbitrary phase
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flashCnt_reg <= 24'h0;
      flash_reg    <= 1'b0;
    end else if (clkEn) begin
      if (flashCnt_reg == `FLASH_CYCLES) begin
        flashCnt_reg <= 24'h0;
        flash_reg    <= !flash_reg;
      end else begin
        flashCnt_reg <= flashCnt_reg + 24'h1;
      end
    end
  end

  // Lamp colour; output only, nothing reads it back
  lamp_color_t lampColor;
  always_comb begin
    if (sOvr) lampColor = flash_reg ? LAMP_WHITE : LAMP_OFF;
    else if (sMute) lampColor = LAMP_WHITE;
    else if (!lampComb_reg || !lampSafeEn_reg) lampColor = LAMP_OFF;
    else if (sSafe) lampColor = LAMP_GREEN;
    else lampColor = LAMP_RED;
  end

  // Registered lamp drive; the valid gate keeps it dark out of reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lampWhite <= 1'b0;
      lampGreen <= 1'b0;
      lampRed   <= 1'b0;
    end else if (clkEn) begin
      lampWhite <= valid_reg && lampColor == LAMP_WHITE;
      lampGreen <= valid_reg && lampColor == LAMP_GREEN;
      lampRed   <= valid_reg && lampColor == LAMP_RED;
    end
  end

  // Power-up signal strength display timer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      showCnt_reg  <= 32'h0;
      showDone_reg <= 1'b0;
    end else if (clkEn && !showDone_reg) begin
      if (showCnt_reg == 32'(SHOW_CYCLES - 1)) showDone_reg <= 1'b1;
      else showCnt_reg <= showCnt_reg + 32'h1;
    end
  end

  // Configuration overrides the timeout
  always_ff @(posedge clk) begin
    if (!rst_n) sigShow <= 1'b0;
    else if (clkEn) sigShow <= !showDone_reg || cfgActive_reg;
  end

  // Card transfer strobes: one-cycle pulses, ignored while busy
  // A request during a transfer is dropped, not queued
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cardLoad <= 1'b0;
      cardSave <= 1'b0;
    end else if (clkEn) begin
      cardLoad <= wrEn && isAddr(paddr, `OFS_CARD) && !sBusy && pwdata[`CARD_LOAD_BIT];
      cardSave <= wrEn && isAddr(paddr, `OFS_CARD) && !sBusy && !pwdata[`CARD_LOAD_BIT]
                  && pwdata[`CARD_SAVE_BIT];
    end
  end

  // Event detection
  // Delay flops reset low, the idle level of every source
  logic [`IRQ_WIDTH-1:0] evt;
  assign evt[`IRQ_SIG_DONE]  = showDly_reg && !sigShow;
  assign evt[`IRQ_CARD_DONE] = busyDly_reg && !sBusy;
  assign evt[`IRQ_WAKE]      = sWake && !wakeDly_reg;

  // Sticky status; set wins over clear
  // An event in the clear cycle is kept, so none is lost
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irqStat_reg <= '0;
      irqEn_reg   <= '0;
      busyDly_reg <= 1'b0;
      showDly_reg <= 1'b0;
    end else if (clkEn) begin
      busyDly_reg <= sBusy;
      showDly_reg <= sigShow;
      if (wrEn && isAddr(paddr, `OFS_IRQ_CLR))
        irqStat_reg <= (irqStat_reg & ~pwdata[`IRQ_WIDTH-1:0]) | evt;
      else
        irqStat_reg <= irqStat_reg | evt;
      if (wrEn && isAddr(paddr, `OFS_IRQ_EN)) irqEn_reg <= pwdata[`IRQ_WIDTH-1:0];
    end
  end

  // Level interrupt
  // Combinational, so it drops right after a clear or mask write
  assign irq = |(irqStat_reg & irqEn_reg);

endmodule
`default_nettype wire

// [status_lamp_properties.sv]
// Port checker for the status output and lamp block.
// Assumes bind to the top module and clkEn held high by the bench.
`timescale 1ns/10ps
`default_nettype none
module status_lamp_properties #(
  parameter int SHOW_CYCLES = 20
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic safety_switching_outputs,
  input wire logic mutingActive,
  input wire logic overrideActive,
  input wire logic wakeRequest,
  input wire logic cardLoad,
  input wire logic cardSave,
  input wire logic lineOut,
  input wire logic lineOe_n,
  input wire logic lineCommMode,
  input wire logic lampWhite,
  input wire logic lampGreen,
  input wire logic lampRed,
  input wire logic sigShow
);
  logic [2:0] upCnt;  // Cycles since release, saturating
  logic       settled; // Pin history valid again
  // Sync chain must refill before pin history means anything
  always_ff @(posedge clk) begin
    if (!rst_n) upCnt <= 3'h0;
    else if (upCnt != 3'h5) upCnt <= upCnt + 3'h1;
  end
  assign settled = (upCnt == 3'h5);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_reset_quiet: assert property ($rose(rst_n) |->
    !lineOut && !lampWhite && !lampGreen && !lampRed)
    else $error("outputs active right after reset");
  a_green_safe_on: assert property (settled && lampGreen |->
    $past(safety_switching_outputs, 3) && !$past(mutingActive, 3))
    else $error("green lamp without safety outputs on");
  a_red_safe_off: assert property (settled && lampRed |->
    !$past(safety_switching_outputs, 3) && !$past(mutingActive, 3))
    else $error("red lamp with safety outputs on or muting");
  a_mute_white: assert property (settled && $past(mutingActive, 3)
    && !$past(overrideActive, 3) |-> lampWhite)
    else $error("muting not shown white");
  a_lamp_one_colour: assert property ($onehot0({lampWhite, lampGreen, lampRed}))
    else $error("two lamp colours at once");
  a_switch_drives: assert property (settled && !lineCommMode
    && !$past(lineCommMode) |-> !lineOe_n)
    else $error("line not driven in switching mode");
  a_wake_comm: assert property ($rose(wakeRequest) |-> ##[1:5] lineCommMode)
    else $error("wake-up did not enter communication");
  a_load_pulse: assert property (cardLoad |=> !cardLoad)
    else $error("card load longer than one cycle");
  a_card_single: assert property (!(cardLoad && cardSave))
    else $error("card load and save together");
  a_show_power_up: assert property ($rose(rst_n) |-> ##[1:3] sigShow)
    else $error("signal display not shown after reset");
  c_green: cover property (lampGreen);
  c_comm: cover property ($rose(lineCommMode));
  c_save: cover property (cardSave);
endmodule
bind status_output_and_lamp_logic status_lamp_properties #(.SHOW_CYCLES(SHOW_CYCLES)) props_u (
  .clk(clk), .rst_n(rst_n), .safety_switching_outputs(safety_switching_outputs),
  .mutingActive(mutingActive), .overrideActive(overrideActive), .wakeRequest(wakeRequest),
  .cardLoad(cardLoad), .cardSave(cardSave), .lineOut(lineOut), .lineOe_n(lineOe_n),
  .lineCommMode(lineCommMode), .lampWhite(lampWhite), .lampGreen(lampGreen),
  .lampRed(lampRed), .sigShow(sigShow));
`default_nettype wire

// [line_partner_model.sv]
// Far side: controller input, wake-up master and card controller.
// Assumes one clock shared with the block.
`timescale 1ns/10ps
`default_nettype none
module line_partner_model #(
  parameter int BUSY = 30
) (
  input  wire logic       clk,
  input  wire logic       lineOut,
  input  wire logic       lineOe_n,
  input  wire logic       wakeCmd,
  input  wire logic       cardLoad,
  input  wire logic       cardSave,
  output logic            lineLevel,
  output logic            wakeRequest,
  output logic            cardBusy,
  output logic      [7:0] loadCnt,
  output logic      [7:0] saveCnt
);
  int busyLeft = 0; // Card work still to do
  int wakeLeft = 0; // Wake pulse length left
  // Input has a pull-down, so a released line reads low
  assign lineLevel = !lineOe_n ? lineOut : 1'b0;
  initial begin
    loadCnt = 8'h00;
    saveCnt = 8'h00;
  end
  // Wake-up pulse from the master on request
  always @(posedge clk) begin
    if (wakeCmd) wakeLeft <= 8;
    else if (wakeLeft > 0) wakeLeft <= wakeLeft - 1;
  end
  assign wakeRequest = (wakeLeft > 0);
  // Card transfer takes a while; busy covers it
  always @(posedge clk) begin
    if (cardLoad) loadCnt <= loadCnt + 8'h01;
    if (cardSave) saveCnt <= saveCnt + 8'h01;
    if (cardLoad || cardSave) busyLeft <= BUSY;
    else if (busyLeft > 0) busyLeft <= busyLeft - 1;
  end
  assign cardBusy = (busyLeft > 0);
endmodule
`default_nettype wire

// [test_status_output_and_lamp_logic.sv]
// Bench for the status output and lamp block over APB.
// Assumes the partner model and checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "status_lamp_defines.svh"
module test_status_output_and_lamp_logic;
  import status_lamp_pkg::*;
  localparam int SHOW = 20; // Short display time for sim
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, ovr = 0, wakeCmd = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic [5:0]  pins = 6'h00; // ack,safe,mute,dirt,sync,ready
  logic pready, pslverr, rerr, cardBusy, cardLoad, cardSave, lineOut, lineOe_n, lineLevel;
  logic lineCommMode, lampWhite, lampGreen, lampRed, sigShow, irq, wakeRequest;
  logic [7:0] loadCnt, saveCnt, lampCase [8];
  int bad_count = 0, check_count = 0, n;
  always #20 clk = ~clk;
  status_output_and_lamp_logic #(.SHOW_CYCLES(SHOW)) dut_u (.clk(clk), .rst_n(rst_n),
    .clkEn(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ackPending(pins[0]), .safety_switching_outputs(pins[1]), .mutingActive(pins[2]),
    .overrideActive(ovr), .dirtWarning(pins[3]), .syncRun(pins[4]),
    .protective_sensor_unitReady(pins[5]), .wakeRequest(wakeRequest), .cardBusy(cardBusy),
    .cardLoad(cardLoad), .cardSave(cardSave), .lineOut(lineOut), .lineOe_n(lineOe_n),
    .lineCommMode(lineCommMode), .lampWhite(lampWhite), .lampGreen(lampGreen),
    .lampRed(lampRed), .sigShow(sigShow), .irq(irq));
  line_partner_model partner_u (.clk(clk), .lineOut(lineOut), .lineOe_n(lineOe_n),
    .wakeCmd(wakeCmd), .cardLoad(cardLoad), .cardSave(cardSave), .lineLevel(lineLevel),
    .wakeRequest(wakeRequest), .cardBusy(cardBusy), .loadCnt(loadCnt), .saveCnt(saveCnt));
  // Verdict and end of run, also reached on a hang
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Compare and report
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer, entered just after an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin bad_count++; wrap_up(); end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdata, exp);
  endtask
  task automatic waitc(input int c);
    repeat (c) @(posedge clk);
  endtask
  // Main sequence
  initial begin
    // Lamp table: mode {display enable, combined}, safe, mute, white, green, red
    lampCase = '{8'h72, 8'h61, 8'h7c, 8'h30, 8'h2c, 8'h10, 8'h1c, 8'h40};
    waitc(10);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({lineOut, lampWhite, lampGreen, lampRed}, 0);
    rdc(`OFS_SRC, SRC_ACK);
    rdc(`OFS_LAMP, `LAMP_RESET);
    chk(sigShow, 1);
    // Seven edges since release; two more for output flop and sampling
    n = 7;
    while (sigShow === 1'b1 && n < 60) begin @(posedge clk); n++; end
    chk({sigShow, 1'(n > SHOW && n <= SHOW + 2)}, 2'b01);
    rdc(`OFS_IRQ_STAT, 32'h1);
    chk(irq, 0); // Masked event stays quiet
    apb(1'b1, `OFS_IRQ_EN, 32'h7);
    chk(irq, 1); // Enabled event raises the line
    apb(1'b1, `OFS_IRQ_CLR, 32'h1);
    chk(irq, 0); // Cleared
    rdc(`OFS_IRQ_CLR, 32'h0); // Clear register reads zero
    apb(1'b1, `OFS_CTRL, 32'h1);
    waitc(SHOW + 10);
    chk(sigShow, 1);
    apb(1'b1, `OFS_CTRL, 32'h0);
    // Every source, its own pin alone then every other pin; off with every pin high both times
    for (int s = 0; s < 7; s++) begin
      apb(1'b1, `OFS_SRC, 32'(s));
      pins <= (s == 6) ? 6'h3f : 6'(1 << s);
      waitc(5);
      chk(lineOut, 32'(s != 6));
      chk(lineLevel, lineOut);
      pins <= 6'h3f ^ ((s == 6) ? 6'h00 : 6'(1 << s));
      waitc(5);
      chk(lineOut, 0);
    end
    apb(1'b1, `OFS_SRC, 32'h7);
    rdc(`OFS_SRC, SRC_OFF);
    apb(1'b1, `OFS_SRC, SRC_SAFE);
    // Lamp modes against safety and muting states
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, `OFS_LAMP, 32'(lampCase[i][6:5]));
      pins <= {3'b000, lampCase[i][3], lampCase[i][4], 1'b0};
      waitc(5);
      chk({lampWhite, lampGreen, lampRed}, lampCase[i][2:0]);
      chk(lineOut, lampCase[i][4]);
    end
    // Override hides green and red; flash phase stays dark this early
    apb(1'b1, `OFS_LAMP, 32'h3);
    pins <= 6'h02;
    ovr <= 1'b1;
    waitc(5);
    chk({lampGreen, lampRed}, 0);
    chk(lineOut, 1);
    ovr <= 1'b0;
    // Card load, save refused while busy, then save, then both
    apb(1'b1, `OFS_CARD, 32'h1);
    waitc(4);
    apb(1'b1, `OFS_CARD, 32'h2);
    n = 0;
    while (cardBusy !== 1'b0 && n < 100) begin @(posedge clk); n++; end
    if (n >= 100) begin bad_count++; wrap_up(); end
    waitc(4);
    chk({loadCnt, saveCnt}, 16'h0100);
    // Display-end event came back when configuration stopped
    rdc(`OFS_IRQ_STAT, 32'h3);
    apb(1'b1, `OFS_CARD, 32'h2);
    waitc(40);
    apb(1'b1, `OFS_CARD, 32'h3);
    waitc(3);
    chk({loadCnt, saveCnt}, 16'h0201);
    // Wake-up into communication, software return
    wakeCmd <= 1'b1;
    @(posedge clk);
    wakeCmd <= 1'b0;
    waitc(6);
    chk(lineCommMode, 1);
    rdc(`OFS_CTRL, 32'h2);
    apb(1'b1, `OFS_CTRL, 32'h4);
    waitc(2);
    chk({lineCommMode, lineOe_n}, 0);
    rdc(12'h020, 32'h0); // Unmapped reads zero
    chk(rerr, 1); // Unmapped flags an error
    wrap_up();
  end
endmodule
`default_nettype wire
